// ===== shared/ddc_redriver_map.svh
`ifndef DDC_REDRIVER_MAP_SVH
`define DDC_REDRIVER_MAP_SVH
`define MGMT_ADDR_BASE 7'h2C
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define CTRL_PD_BIT 0
`define CTRL_BUF_BIT 1
`define CTRL_SNOOP_BIT 2
`define CTRL_RESET 8'h05
`define SNOOP_DEV_ADDR 8'hA8
`define SNOOP_OFFSET 8'h20
`define SNOOP_RATIO_BIT 1
`define STRAP_SETTLE 2'h3
`define BYTE_BITS 4'h8
`define ACK_SLOT 4'h9
`define HOST_CMD_ADDR 8'h00
`define HOST_STATUS_ADDR 8'h04
`define HOST_STRAP_ADDR 8'h08
`define CLK_NS 25
`define I2C_QTR_NS 125
`define I2C_QTR_CYC ((`I2C_QTR_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== shared/ddc_redriver_pkg.sv
package ddc_redriver_pkg;
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00,
    LVL_RES = 2'b01,
    LVL_FLOAT = 2'b10,
    LVL_HIGH = 2'b11
  } strap_level_t;
  typedef struct packed {
    logic linear;
    logic [1:0] emph;
    logic [1:0] swing;
    logic [1:0] eq;
    logic cfg1;
    logic hpd_sel;
    logic ac;
    logic addr;
    strap_level_t mode;
  } strap_t;
  typedef struct packed {
    logic serial_mode;
    logic powered_down;
    logic buffer_on;
    logic snoop_on;
    logic high_rate;
    logic term_auto;
    logic term_300;
    logic alt_link;
    logic all_lanes;
    logic lane_swap;
    logic limited;
    logic [1:0] eq;
    logic [1:0] swing;
    logic [1:0] emph;
    logic hpd_sel;
  } cfg_out_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_BYTE = 2'b10,
    M_STOP = 2'b11
  } master_state_t;
  typedef struct packed {
    logic [1:0] hpd_s;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_q;
    logic sda_q;
    strap_t raw0;
    strap_t raw1;
    strap_t cap;
    logic [1:0] settle;
    logic captured;
    logic [7:0] ctrl;
    logic ratio;
    logic act;
    logic rw;
    logic [1:0] bc;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] rd;
    logic sda_oe;
    logic [3:0] n_cnt;
    logic [1:0] n_bc;
    logic [7:0] n_sh;
    logic n_dev_ok;
    logic n_off_ok;
    logic n_scl_q;
    logic n_sda_q;
    logic [1:0] cable_pd;
    logic [1:0] sys_pd;
    logic hpo;
    cfg_out_t o;
  } dev_state_t;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] hrdata;
    logic busy;
    logic nack;
    logic rw;
    logic restart;
    logic [6:0] dev;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic [7:0] sh;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] bn;
    master_state_t ms;
    logic [7:0] div;
    strap_t straps;
    logic hpd;
    logic cfg0;
    logic [1:0] sda_s;
    logic [1:0] hpo_s;
    logic scl;
    logic oe;
  } host_state_t;
endpackage : ddc_redriver_pkg

// ===== shared/ddc_link_if.sv
`timescale 1ns/10ps
interface ddc_link_if;
  import ddc_redriver_pkg::*;
  strap_t straps;
  logic hot_plug_input;
  logic hot_plug_output;
  logic host_cfg0;
  logic host_cfg1_lvl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic first_config_pin;
  logic second_config_pin;
  // Wired-AND of the open-drain data line and the host strap level
  assign first_config_pin = host_cfg0;
  assign second_config_pin = host_cfg1_lvl & (host_sda_oe ? host_sda_out : 1'b1)
                             & (dev_sda_oe ? dev_sda_out : 1'b1);
  modport dev (
    input straps, hot_plug_input, first_config_pin, second_config_pin,
    output hot_plug_output, dev_sda_out, dev_sda_oe
  );
  modport host (
    output straps, hot_plug_input, host_cfg0, host_cfg1_lvl, host_sda_out, host_sda_oe,
    input hot_plug_output, second_config_pin
  );
endinterface : ddc_link_if

// ===== src/ddc_host_end.sv
`timescale 1ns/10ps
`include "ddc_redriver_map.svh"
module ddc_host_end #(
  parameter int QTR_CYC = `I2C_QTR_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  ddc_link_if.host link
);
  import ddc_redriver_pkg::*;
  if (QTR_CYC < 4 || QTR_CYC > 255) begin : g_chk
    $error("QTR_CYC out of range");
  end
  host_state_t s, next_s;
  logic tick;
  logic serial;
  always_comb begin
    next_s = s;
    serial = s.straps.mode == LVL_FLOAT;
    next_s.sda_s = {s.sda_s[0], link.second_config_pin};
    next_s.hpo_s = {s.hpo_s[0], link.hot_plug_output};
    next_s.wr = hsel_in & htrans_in[1] & hready_in & hwrite_in;
    if (hsel_in & htrans_in[1] & hready_in) begin
      next_s.a = haddr_in[7:0];
      if (!hwrite_in) begin
        case (haddr_in[7:0])
          `HOST_CMD_ADDR: next_s.hrdata = {1'b0, s.dev, s.wdata, s.ptr, 6'h00, s.rw, 1'b0};
          `HOST_STATUS_ADDR: next_s.hrdata = {16'h0000, s.rd, 5'h00, s.hpo_s[1], s.nack, s.busy};
          `HOST_STRAP_ADDR: next_s.hrdata = {17'h00000, s.cfg0, s.hpd, s.straps};
          default: next_s.hrdata = 32'h00000000;
        endcase
      end
    end
    if (s.wr && s.a == `HOST_CMD_ADDR && hwdata_in[0] && !s.busy && serial) begin
      next_s.busy = 1'b1;
      next_s.nack = 1'b0;
      next_s.rw = hwdata_in[1];
      next_s.ptr = hwdata_in[15:8];
      next_s.wdata = hwdata_in[23:16];
      next_s.dev = hwdata_in[30:24];
      next_s.bn = 2'h0;
      next_s.q = 2'h0;
      next_s.ms = M_START;
    end
    if (s.wr && s.a == `HOST_STRAP_ADDR) begin
      next_s.straps = strap_t'(hwdata_in[12:0]);
      next_s.hpd = hwdata_in[13];
      next_s.cfg0 = hwdata_in[14];
    end
    tick = s.div == 8'(QTR_CYC - 1);
    next_s.div = (s.ms == M_IDLE || tick) ? 8'h00 : s.div + 8'h01;
    if (tick) begin
      next_s.q = s.q + 2'h1;
      case (s.ms)
        M_START: begin
          next_s.oe = s.q >= 2'h1;
          next_s.scl = s.q != 2'h3;
          if (s.q == 2'h3) begin
            next_s.ms = M_BYTE;
            next_s.bitn = 4'h0;
            next_s.sh = s.bn == 2'h0 ? {s.dev, 1'b0} :
                        s.bn == 2'h2 ? {s.dev, 1'b1} : s.ptr;
          end
        end
        M_BYTE: begin
          next_s.scl = s.q == 2'h0 || s.q == 2'h1;
          if (s.q == 2'h0) begin
            next_s.oe = s.bitn < `BYTE_BITS && s.bn != 2'h3 && !s.sh[7];
          end
          if (s.q == 2'h2) begin
            if (s.bitn < `BYTE_BITS) begin
              next_s.rd = {s.rd[6:0], s.sda_s[1]};
            end else if (s.bn != 2'h3 && s.sda_s[1]) begin
              next_s.nack = 1'b1;
            end
          end
          if (s.q == 2'h3) begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.bitn = s.bitn + 4'h1;
            if (s.bitn == `BYTE_BITS) begin
              next_s.bitn = 4'h0;
              next_s.bn = s.bn + 2'h1;
              next_s.sh = s.bn == 2'h0 ? s.ptr : s.wdata;
              if (s.nack || (!s.rw && s.bn == 2'h2) || s.bn == 2'h3) begin
                next_s.ms = M_STOP;
              end else if (s.rw && s.bn == 2'h1) begin
                next_s.ms = M_STOP;
                next_s.restart = 1'b1;
              end
            end
          end
        end
        M_STOP: begin
          next_s.scl = s.q != 2'h0;
          next_s.oe = s.q <= 2'h1;
          if (s.q == 2'h3) begin
            next_s.restart = 1'b0;
            next_s.ms = s.restart ? M_START : M_IDLE;
            next_s.busy = s.restart;
          end
        end
        default: begin
          next_s.scl = 1'b1;
          next_s.oe = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.scl <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign hrdata_out = s.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign link.straps = s.straps;
  assign link.hot_plug_input = s.hpd;
  assign link.host_cfg0 = serial ? s.scl : s.cfg0;
  assign link.host_cfg1_lvl = serial ? 1'b1 : s.straps.cfg1;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = serial & s.oe;
endmodule : ddc_host_end

// ===== src/ddc_device_end.sv
// Added by the designer: the register offsets and the serial management slave.
`timescale 1ns/10ps
`include "ddc_redriver_map.svh"
// Function
// - Mode strap picks buffer and operating mode
// - Snoop on strapped unless alternate link; register-gated serially
// - Address strap picks management bus address
// - Serial mode ignores straps except address; config pins bus
// - Serial mode starts powered down until cleared
// - Powerdown request forces hot-plug output low
// - Serial buffer follows buffer enable bit
// - First pin selects auto or forced termination
// - First pin with coupling selects alternate link
// - Second pin selects full lane swap
// - Only first pin sampled continuously
// - Sampled equalizer pair applied outside serial mode
// - Limited mode flagged; swing and emphasis levels follow straps
// - Two open-drain channels, clock and data
// - System low turns on cable pulldown
// - System rising above threshold releases cable
// - Cable falling first pulls system side low
// - Cable pulldown held until hysteresis crossed
// - No external system-side pullups with buffer
// - Unused side pins left floating
// - Snoop offset 20h bit 1 sets rate
// - Powerdown and reset revert to low rate
module ddc_device_end (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] sys_low_in,
  input wire logic [1:0] sys_above_in,
  input wire logic [1:0] cable_low_in,
  output logic [1:0] sys_pd_out,
  output logic [1:0] cable_pd_out,
  output ddc_redriver_pkg::cfg_out_t cfg_out,
  ddc_link_if.dev link
);
  import ddc_redriver_pkg::*;
  dev_state_t s, next_s;
  logic serial, pd, hpd, cfg0, alt, buf_en, snoop_en;
  logic scl_rise, scl_fall, start, stop;
  logic n_rise, n_start, n_line_scl, n_line_sda;
  logic [6:0] my_addr;
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input dev_state_t st);
    case (idx)
      `REG_CTRL: reg_read = st.ctrl;
      `REG_STATUS: reg_read = {4'h0, st.cap.mode, st.hpd_s[1], st.ratio};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read
  always_comb begin
    next_s = s;
    next_s.hpd_s = {s.hpd_s[0], link.hot_plug_input};
    next_s.scl_s = {s.scl_s[0], link.first_config_pin};
    next_s.sda_s = {s.sda_s[0], link.second_config_pin};
    next_s.scl_q = s.scl_s[1];
    next_s.sda_q = s.sda_s[1];
    next_s.raw0 = link.straps;
    next_s.raw1 = s.raw0;
    hpd = s.hpd_s[1];
    cfg0 = s.scl_s[1];
    if (!s.captured) begin
      next_s.settle = s.settle + 2'h1;
      if (s.settle == `STRAP_SETTLE) begin
        next_s.cap = s.raw1;
        next_s.captured = 1'b1;
      end
    end
    serial = s.captured && s.cap.mode == LVL_FLOAT;
    alt = s.captured && !serial && s.cap.ac && cfg0;
    pd = !s.captured || (serial ? s.ctrl[`CTRL_PD_BIT] : !hpd);
    snoop_en = serial ? s.ctrl[`CTRL_SNOOP_BIT] : !alt;
    buf_en = !pd && hpd && (serial ? s.ctrl[`CTRL_BUF_BIT] :
                            (s.cap.mode == LVL_LOW && !alt));
    my_addr = {6'(`MGMT_ADDR_BASE >> 1), s.cap.addr};
    scl_rise = s.scl_s[1] && !s.scl_q;
    scl_fall = !s.scl_s[1] && s.scl_q;
    start = s.scl_s[1] && s.scl_q && s.sda_q && !s.sda_s[1];
    stop = s.scl_s[1] && s.scl_q && !s.sda_q && s.sda_s[1];
    if (!serial) begin
      next_s.act = 1'b0;
      next_s.sda_oe = 1'b0;
      next_s.cnt = 4'h0;
    end else if (start || stop) begin
      next_s.act = 1'b0;
      next_s.sda_oe = 1'b0;
      next_s.cnt = 4'h0;
      next_s.bc = 2'h0;
    end else if (scl_rise) begin
      if (s.cnt < `BYTE_BITS) begin
        next_s.sh = {s.sh[6:0], s.sda_s[1]};
      end else if (s.act && s.rw && s.sda_s[1]) begin
        next_s.act = 1'b0;
      end
      next_s.cnt = s.cnt + 4'h1;
    end else if (scl_fall) begin
      if (s.cnt == `BYTE_BITS) begin
        next_s.sda_oe = 1'b0;
        if (s.bc == 2'h0) begin
          next_s.act = s.sh[7:1] == my_addr;
          next_s.rw = s.sh[0];
          next_s.sda_oe = s.sh[7:1] == my_addr;
        end else if (s.act && !s.rw) begin
          next_s.sda_oe = 1'b1;
          if (s.bc == 2'h1) begin
            next_s.ptr = s.sh;
          end else if (s.ptr == `REG_CTRL) begin
            next_s.ctrl = s.sh;
          end
        end
      end else if (s.cnt == `ACK_SLOT) begin
        next_s.cnt = 4'h0;
        next_s.bc = (s.bc == 2'h3) ? s.bc : s.bc + 2'h1;
        next_s.sda_oe = 1'b0;
        if (s.act && s.rw) begin
          next_s.rd = reg_read(s.ptr, s);
          next_s.sda_oe = !next_s.rd[7];
        end
      end else if (s.act && s.rw && s.cnt != 4'h0) begin
        next_s.sda_oe = !s.rd[3'(4'h7 - s.cnt)];
      end
    end
    n_line_scl = !sys_low_in[0];
    n_line_sda = !sys_low_in[1];
    next_s.n_scl_q = n_line_scl;
    next_s.n_sda_q = n_line_sda;
    n_rise = n_line_scl && !s.n_scl_q;
    n_start = n_line_scl && s.n_scl_q && s.n_sda_q && !n_line_sda;
    if (n_start) begin
      next_s.n_cnt = 4'h0;
      next_s.n_bc = 2'h0;
    end else if (n_rise) begin
      next_s.n_cnt = s.n_cnt + 4'h1;
      if (s.n_cnt < `BYTE_BITS) begin
        next_s.n_sh = {s.n_sh[6:0], n_line_sda};
      end else begin
        next_s.n_cnt = 4'h0;
        next_s.n_bc = (s.n_bc == 2'h3) ? s.n_bc : s.n_bc + 2'h1;
        case (s.n_bc)
          2'h0: next_s.n_dev_ok = s.n_sh == `SNOOP_DEV_ADDR;
          2'h1: next_s.n_off_ok = s.n_sh == `SNOOP_OFFSET;
          2'h2: begin
            if (snoop_en && s.n_dev_ok && s.n_off_ok) begin
              next_s.ratio = s.n_sh[`SNOOP_RATIO_BIT];
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (pd) begin
      next_s.ratio = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (!buf_en) begin
        next_s.cable_pd[i] = 1'b0;
        next_s.sys_pd[i] = 1'b0;
      end else begin
        next_s.cable_pd[i] = s.cable_pd[i] ? !sys_above_in[i] :
                             sys_low_in[i] && !s.sys_pd[i];
        next_s.sys_pd[i] = cable_low_in[i] && !s.cable_pd[i];
      end
    end
    next_s.hpo = hpd && !pd;
    next_s.o.serial_mode = serial;
    next_s.o.powered_down = pd;
    next_s.o.buffer_on = buf_en;
    next_s.o.snoop_on = snoop_en;
    next_s.o.high_rate = s.ratio;
    next_s.o.term_auto = s.captured && !serial && !s.cap.ac && !cfg0;
    next_s.o.term_300 = s.captured && !serial && !s.cap.ac && cfg0;
    next_s.o.alt_link = alt;
    next_s.o.all_lanes = alt && hpd;
    next_s.o.lane_swap = !serial && s.cap.cfg1;
    next_s.o.limited = !serial && !s.cap.linear;
    next_s.o.eq = serial ? 2'h0 : s.cap.eq;
    next_s.o.swing = serial ? 2'h0 : s.cap.swing;
    next_s.o.emph = serial ? 2'h0 : s.cap.emph;
    next_s.o.hpd_sel = !serial && s.cap.hpd_sel;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.o.powered_down <= 1'b1;
      // Idle-high line history, so no false edge follows reset
      s.scl_s <= 2'h3;
      s.sda_s <= 2'h3;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.n_scl_q <= 1'b1;
      s.n_sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign sys_pd_out = s.sys_pd;
  assign cable_pd_out = s.cable_pd;
  assign cfg_out = s.o;
  assign link.hot_plug_output = s.hpo;
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = s.sda_oe;
endmodule : ddc_device_end

// ===== sim/ddc_redriver_sva.sv
`timescale 1ns/10ps
module ddc_redriver_sva
  import ddc_redriver_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] sys_low_in,
  input wire logic [1:0] sys_above_in,
  input wire logic [1:0] cable_low_in,
  input wire logic [1:0] sys_pd_out,
  input wire logic [1:0] cable_pd_out,
  input wire ddc_redriver_pkg::cfg_out_t cfg_out,
  input wire logic hot_plug_output
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  cable_on_a: assert property (
    cfg_out.buffer_on [*2] ##0 sys_low_in[0] && !sys_pd_out[0] |=> cable_pd_out[0])
    else $error("cable pulldown missing");
  cable_off_a: assert property (
    sys_above_in[0] |=> !cable_pd_out[0]) else $error("cable pulldown kept");
  cable_hold_a: assert property (
    cable_pd_out[1] && !sys_above_in[1] && cfg_out.buffer_on |=> cable_pd_out[1])
    else $error("cable pulldown dropped early");
  sys_pull_a: assert property (
    cfg_out.buffer_on [*2] ##0 cable_low_in[1] && !cable_pd_out[1] |=> sys_pd_out[1])
    else $error("system pulldown missing");
  pd_idle_a: assert property (
    !cfg_out.buffer_on [*3] |-> sys_pd_out == 2'h0 && cable_pd_out == 2'h0)
    else $error("pulldown while buffer off");
  hpo_low_a: assert property (
    cfg_out.powered_down [*3] |-> !hot_plug_output) else $error("hot plug out high");
  serial_pd_a: assert property (
    $rose(cfg_out.serial_mode) |-> cfg_out.powered_down) else $error("serial not powered down");
  alt_snoop_a: assert property (
    cfg_out.alt_link |-> !cfg_out.snoop_on && !cfg_out.serial_mode)
    else $error("snoop on in alternate mode");
  rate_low_a: assert property (
    cfg_out.powered_down [*2] |-> !cfg_out.high_rate) else $error("high rate while down");
  cover property ($rose(cable_pd_out[0]));
  cover property ($rose(sys_pd_out[1]));
  cover property ($rose(cfg_out.high_rate));
endmodule : ddc_redriver_sva

// ===== sim/strap_mode_and_ddc_buffer_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module strap_mode_and_ddc_buffer_ctrl_tb;
  import ddc_redriver_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic dev_rst = 1'h1;
  logic hsel = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic [1:0] sl = 2'h0;
  logic [1:0] sa = 2'h3;
  logic [1:0] cl = 2'h0;
  logic [1:0] spd;
  logic [1:0] cpd;
  cfg_out_t cfg;
  logic [31:0] st;
  int bad_count = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  ddc_link_if ddc_link_if_inst();
  ddc_host_end ddc_host_end_inst (.clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
    .link(ddc_link_if_inst.host));
  ddc_device_end ddc_device_end_inst (.clk_in(clk), .rst_in(dev_rst), .sys_low_in(sl),
    .sys_above_in(sa), .cable_low_in(cl), .sys_pd_out(spd), .cable_pd_out(cpd), .cfg_out(cfg),
    .link(ddc_link_if_inst.dev));
  ddc_redriver_sva ddc_redriver_sva_inst (.clk_in(clk), .rst_in(dev_rst), .sys_low_in(sl),
    .sys_above_in(sa), .cable_low_in(cl), .sys_pd_out(spd), .cable_pd_out(cpd), .cfg_out(cfg),
    .hot_plug_output(ddc_link_if_inst.hot_plug_output));
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      bad_count++;
      give_verdict();
    end
  endtask : bus
  task automatic mgmt(input logic [31:0] cmd);
    int n;
    bus(1'h1, 32'h0, cmd, st);
    n = 0;
    do begin bus(1'h0, 32'h4, 32'h0, st); n++; end while (st[0] !== 1'h0 && n < 1000);
    if (n >= 1000) begin
      bad_count++;
      give_verdict();
    end
  endtask : mgmt
  task automatic set_straps(input logic [31:0] v, input logic rs);
    bus(1'h1, 32'h8, v, st);
    if (rs) begin
      dev_rst <= 1'h1;
      tick(2);
      dev_rst <= 1'h0;
    end
    tick(10);
  endtask : set_straps
  task automatic line(input logic c, input logic d);
    sl <= {~d, ~c};
    sa <= {d, c};
    tick(4);
  endtask : line
  task automatic t_strap();
    set_straps(32'h2DB0, 1'h1);
    `CHK("buffer", 1'h1, cfg.buffer_on)
    `CHK("hpd sel", 1'h1, cfg.hpd_sel)
    `CHK("snoop", 1'h1, cfg.snoop_on)
    `CHK("swap", 1'h1, cfg.lane_swap)
    `CHK("eq", 2'h2, cfg.eq)
    `CHK("swing emph", 5'h0F, {cfg.swing, cfg.emph, cfg.limited})
    `CHK("term auto", 1'h1, cfg.term_auto)
    bus(1'h0, 32'h4, 32'h0, st);
    `CHK("hpo", 1'h1, st[2])
    sl <= 2'h1;
    sa <= 2'h2;
    tick(3);
    `CHK("cable pd", 2'h1, cpd)
    `CHK("sys pd idle", 2'h0, spd)
    sl <= 2'h0;
    tick(3);
    `CHK("cable hold", 2'h1, cpd)
    sa <= 2'h3;
    tick(3);
    `CHK("cable free", 2'h0, cpd)
    cl <= 2'h2;
    tick(3);
    `CHK("sys pd", 2'h2, spd)
    `CHK("no echo", 2'h0, cpd)
    cl <= 2'h0;
    tick(3);
    `CHK("sys free", 2'h0, spd)
    set_straps(32'h6D80, 1'h0);
    `CHK("swap held", 1'h1, cfg.lane_swap)
    `CHK("hpd sel held", 1'h1, cfg.hpd_sel)
    `CHK("term 300", 2'h1, {cfg.term_auto, cfg.term_300})
    $display("test strap done");
  endtask : t_strap
  task automatic t_snoop();
    logic [7:0] b [3];
    logic [8:0] v;
    b = '{8'hA8, 8'h20, 8'h02};
    line(1'h1, 1'h0);
    for (int i = 0; i < 3; i++) begin
      v = {b[i], 1'h0};
      for (int k = 8; k >= 0; k--) begin
        line(1'h0, v[k]);
        line(1'h1, v[k]);
      end
    end
    line(1'h0, 1'h0);
    line(1'h1, 1'h0);
    line(1'h1, 1'h1);
    `CHK("high rate", 1'h1, cfg.high_rate)
    set_straps(32'h4D80, 1'h0);
    `CHK("rate down", 2'h2, {cfg.powered_down, cfg.high_rate})
    set_straps(32'h6D80, 1'h0);
    `CHK("rate kept low", 1'h0, cfg.high_rate)
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_modes();
    logic [31:0] sv [4];
    logic [2:0] ex [4];
    sv = '{32'h2001, 32'h2003, 32'h6008, 32'h2008};
    ex = '{3'h2, 3'h2, 3'h1, 3'h6};
    for (int i = 0; i < 4; i++) begin
      set_straps(sv[i], 1'h1);
      `CHK("buf snoop alt", ex[i], {cfg.buffer_on, cfg.snoop_on, cfg.alt_link})
      `CHK("swap off", 1'h0, cfg.lane_swap)
      `CHK("all lanes", ex[i][0], cfg.all_lanes)
      sl <= 2'h1;
      sa <= 2'h2;
      tick(3);
      `CHK("cable pd", {1'h0, ex[i][2]}, cpd)
      sl <= 2'h0;
      sa <= 2'h3;
      tick(3);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_serial();
    set_straps(32'h2026, 1'h1);
    `CHK("serial", 3'h7, {cfg.serial_mode, cfg.powered_down, cfg.snoop_on})
    `CHK("strap ignored", 1'h0, cfg.lane_swap)
    `CHK("hpo low", 1'h0, ddc_link_if_inst.hot_plug_output)
    mgmt(32'h2C020001);
    `CHK("nack", 2'h3, {st[1], cfg.powered_down})
    mgmt(32'h2D020001);
    tick(4);
    `CHK("ack", 1'h0, st[1])
    `CHK("ctrl", 3'h2, {cfg.powered_down, cfg.buffer_on, cfg.snoop_on})
    `CHK("hpo high", 1'h1, ddc_link_if_inst.hot_plug_output)
    mgmt(32'h2D000003);
    `CHK("ctrl read", 8'h02, st[15:8])
    mgmt(32'h2D050001);
    tick(4);
    `CHK("buf off", 2'h0, {cfg.buffer_on, ddc_link_if_inst.hot_plug_output})
    $display("test serial done");
  endtask : t_serial
  initial begin
    tick(20);
    rst <= 1'h0;
    dev_rst <= 1'h0;
    tick(2);
    t_strap();
    t_snoop();
    t_modes();
    t_serial();
    give_verdict();
  end
endmodule : strap_mode_and_ddc_buffer_ctrl_tb
